// ### dv/tb_cie_core.sv
// Self-checking random testbench for the instruction executor
module tb_cie_core;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [13:0] i_insn = 14'h0000;
	logic [7:0] i_reg_rdata = 8'h00;
	logic [12:0] i_stack_head = 13'h0000;
	logic [4:0] i_pc_upper_latch = 5'h00;
	logic [12:0] o_pc, o_stack_push_data, m_pc;
	logic [6:0] o_reg_addr;
	cie_pkg::cie_wr_type o_reg_wr;
	logic [7:0] o_acc, m_acc;
	logic o_zero, o_expiry_flag_n, o_sleep_flag_n, o_global_irq_enable;
	logic o_stack_push, o_stack_pop, o_watchdog_clear, o_flush, m_z, m_g, m_f;
	int errors = 0;
	int samples_checked = 0;
	logic [13:0] base [17];
	logic [13:0] mask [17];
	cie_core cie_core_i (.i_clk(i_clk), .i_reset(i_reset), .i_insn(i_insn), .i_reg_rdata(i_reg_rdata),
		.i_stack_head(i_stack_head), .i_pc_upper_latch(i_pc_upper_latch), .o_pc(o_pc),
		.o_reg_addr(o_reg_addr), .o_reg_wr(o_reg_wr), .o_acc(o_acc), .o_zero(o_zero),
		.o_expiry_flag_n(o_expiry_flag_n), .o_sleep_flag_n(o_sleep_flag_n),
		.o_global_irq_enable(o_global_irq_enable), .o_stack_push(o_stack_push),
		.o_stack_push_data(o_stack_push_data), .o_stack_pop(o_stack_pop),
		.o_watchdog_clear(o_watchdog_clear), .o_flush(o_flush));
	initial
	begin
		forever #4 i_clk = ~i_clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		if (errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// Register outputs against the model
	// ----------------------------------------
	task automatic regs();
		chk(o_pc, m_pc);
		chk(o_acc, m_acc);
		chk(o_zero, m_z);
		chk({o_expiry_flag_n, o_sleep_flag_n}, 2'b11);
		chk(o_global_irq_enable, m_g);
		chk(o_flush, m_f);
	endtask
	task automatic rst(input int n);
		i_reset = 1'b1;
		repeat (n) @(negedge i_clk);
		i_reset = 1'b0;
		{m_pc, m_acc, m_z, m_g, m_f} = '0;
		regs();
	endtask
	// ----------------------------------------
	// One cycle: drive, predict, compare
	// ----------------------------------------
	task automatic step(input logic [13:0] w);
		logic [7:0] r, res;
		logic [5:0] o;
		logic we, psh, pop, wdc, skip, alu;
		logic [7:0] wd;
		i_insn = w;
		i_reg_rdata = ($urandom % 2) ? 8'($urandom) : (($urandom % 2) ? 8'h01 : 8'hFF);
		i_stack_head = 13'($urandom);
		i_pc_upper_latch = 5'($urandom);
		r = i_reg_rdata;
		o = w[13:8];
		{we, psh, pop, wdc, skip, wd} = '0;
		alu = !m_f && o inside {cie_pkg::OP6_DEC, cie_pkg::OP6_INC, cie_pkg::OP6_COM, cie_pkg::OP6_MOV,
			cie_pkg::OP6_DECSZ, cie_pkg::OP6_INCSZ};
		res = (o == cie_pkg::OP6_COM) ? ~r : (o == cie_pkg::OP6_MOV) ? r
			: (o inside {cie_pkg::OP6_DEC, cie_pkg::OP6_DECSZ}) ? r - 8'h01 : r + 8'h01;
		#1;
		chk(o_reg_addr, w[6:0]);
		if (m_f)
			;
		else if (w == cie_pkg::OP_CLRACC)
			{m_acc, m_z} = {8'h00, 1'b1};
		else if (w == cie_pkg::OP_WDTCLR)
			wdc = 1'b1;
		else if (w == cie_pkg::OP_IRET)
			pop = 1'b1;
		else if (w[13:10] == cie_pkg::OP4_BTSS)
			skip = r[w[9:7]];
		else if (o == cie_pkg::OP6_CLR && w[7])
			{we, m_z} = 2'b11;
		else if (alu)
		begin
			if (w[7])
				{we, wd} = {1'b1, res};
			else
				m_acc = res;
			if (o inside {cie_pkg::OP6_DECSZ, cie_pkg::OP6_INCSZ})
				skip = (res == 8'h00);
			else
				m_z = (res == 8'h00);
		end
		else if (o == cie_pkg::OP6_ORLIT)
		begin
			m_acc = m_acc | w[7:0];
			m_z = (m_acc == 8'h00);
		end
		else if (w[13:10] == cie_pkg::OP4_LDLIT)
			m_acc = w[7:0];
		else if (o == cie_pkg::OP6_MISC && w[7])
			{we, wd} = {1'b1, m_acc};
		else if (w[13:11] == cie_pkg::OP3_CALL)
			psh = 1'b1;
		chk(o_reg_wr.we, we);
		if (we)
			chk({o_reg_wr.addr, o_reg_wr.data}, {w[6:0], wd});
		chk({o_stack_push, o_stack_pop, o_watchdog_clear}, {psh, pop, wdc});
		if (psh)
			chk(o_stack_push_data, 13'(m_pc + 13'h0001));
		@(negedge i_clk);
		if (m_f)
			;
		else if (pop)
			{m_pc, m_g} = {i_stack_head, 1'b1};
		else if (w[13:12] == 2'b10)
			m_pc = {i_pc_upper_latch[4:3], w[10:0]};
		else if (skip)
			m_pc = m_pc + 13'h0002;
		else
			m_pc = m_pc + 13'h0001;
		m_f = pop || skip || (!m_f && w[13:12] == 2'b10);
		regs();
	endtask
	initial
	begin
		base = '{14'h0103, 14'h0064, 14'h0009, 14'h1C00, 14'h0180, 14'h0300, 14'h0800, 14'h0900, 14'h0A00,
			14'h0B00, 14'h0F00, 14'h3800, 14'h3000, 14'h0080, 14'h2000, 14'h2800, 14'h0000};
		mask = '{14'h0000, 14'h0000, 14'h0000, 14'h03FF, 14'h007F, 14'h00FF, 14'h00FF, 14'h00FF, 14'h00FF,
			14'h00FF, 14'h00FF, 14'h00FF, 14'h03FF, 14'h007F, 14'h07FF, 14'h07FF, 14'h0060};
		void'($urandom(32'h03695422));
		rst(6);
		for (int n = 0; n < 4000; n++)
		begin
			int k;
			k = $urandom % 17;
			step(base[k] | (14'($urandom) & mask[k]));
			if (n == 2000)
				rst(2);
		end
		wrap_up();
	end
endmodule

// ### hw/cie_core.sv
// Execute stage of the 14-bit instruction core
// What this block does
// - Bit test skips next when bit is one
// - Taken skip flushes prefetch, costs one cycle
// - Clear register writes zero, sets zero flag
// - Call pushes return, loads literal and latch
// - Branch loads literal and latch bits only
// - Clear accumulator zeroes it, sets zero flag
// - Watchdog clear resets counter, sets both flags
// - Destination bit picks accumulator or register
// - Decrement, increment store result, update zero
// - Decrement-skip skips on zero, flags untouched
// - Increment-skip skips on zero, flags untouched
// - Complement inverts register, updates zero flag
// - OR literal into accumulator, updates zero
// - Move register to destination, updates zero
// - Interrupt return pops stack, sets enable
module cie_core (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [13:0] i_insn,
	input wire logic [7:0] i_reg_rdata,
	input wire logic [12:0] i_stack_head,
	input wire logic [4:0] i_pc_upper_latch,
	output logic [12:0] o_pc,
	output logic [6:0] o_reg_addr,
	output cie_pkg::cie_wr_type o_reg_wr,
	output logic [7:0] o_acc,
	output logic o_zero,
	output logic o_expiry_flag_n,
	output logic o_sleep_flag_n,
	output logic o_global_irq_enable,
	output logic o_stack_push,
	output logic [12:0] o_stack_push_data,
	output logic o_stack_pop,
	output logic o_watchdog_clear,
	output logic o_flush
);
	cie_pkg::cie_state_type state_reg;
	cie_pkg::cie_state_type state_next;
	logic [5:0] op6;
	logic [2:0] bit_sel;
	logic [7:0] alu;
	logic dest_reg;
	logic skip;
	logic redirect;
	logic exec;

	assign op6 = i_insn[13:8];
	assign bit_sel = i_insn[cie_pkg::BITSEL_LSB +: 3];
	assign o_reg_addr = i_insn[cie_pkg::ADDR_W-1:0];
	assign dest_reg = i_insn[cie_pkg::DEST_BIT];
	assign exec = (state_reg.phase == cie_pkg::ST_EXEC) && !i_reset;

	// ----------------------------------------
	// Decode and execute
	// ----------------------------------------
	always_comb
	begin
		state_next = state_reg;
		o_reg_wr = '0;
		o_reg_wr.addr = o_reg_addr;
		o_stack_push = 1'b0;
		o_stack_pop = 1'b0;
		o_watchdog_clear = 1'b0;
		alu = 8'h00;
		skip = 1'b0;
		redirect = 1'b0;
		if (state_reg.phase == cie_pkg::ST_FLUSH)
		begin
			// Discarded prefetch slot runs as a no-operation
			state_next.phase = cie_pkg::ST_EXEC;
			// Pc holds here so the word at the new pc is refetched and executed next
			state_next.pc = state_reg.pc;
		end
		else
		begin
			state_next.pc = state_reg.pc + 13'h0001;
			if (i_insn == cie_pkg::OP_CLRACC)
			begin
				state_next.acc = 8'h00;
				state_next.zero = 1'b1;
			end
			else if (i_insn == cie_pkg::OP_WDTCLR)
			begin
				o_watchdog_clear = 1'b1;
				state_next.expiry_n = 1'b1;
				state_next.sleep_n = 1'b1;
			end
			else if (i_insn == cie_pkg::OP_IRET)
			begin
				o_stack_pop = 1'b1;
				state_next.irq_en = 1'b1;
				state_next.pc = i_stack_head;
				redirect = 1'b1;
			end
			else if (i_insn[13:11] == cie_pkg::OP3_CALL || i_insn[13:11] == cie_pkg::OP3_GOTO)
			begin
				o_stack_push = (i_insn[13:11] == cie_pkg::OP3_CALL);
				// Upper PC bits come from the latch, not the current page
				state_next.pc = {i_pc_upper_latch[cie_pkg::LATCH_HI:cie_pkg::LATCH_LO], i_insn[10:0]};
				redirect = 1'b1;
			end
			else if (i_insn[13:10] == cie_pkg::OP4_BTSS)
				skip = i_reg_rdata[bit_sel];
			else if (i_insn[13:10] == cie_pkg::OP4_LDLIT)
				state_next.acc = i_insn[7:0];
			else if (op6 == cie_pkg::OP6_ORLIT)
			begin
				alu = state_reg.acc | i_insn[7:0];
				state_next.acc = alu;
				state_next.zero = (alu == 8'h00);
			end
			else if (op6 == cie_pkg::OP6_MISC && dest_reg)
			begin
				o_reg_wr.we = 1'b1;
				o_reg_wr.data = state_reg.acc;
			end
			else if (op6 == cie_pkg::OP6_CLR && dest_reg)
			begin
				o_reg_wr.we = 1'b1;
				state_next.zero = 1'b1;
			end
			else if (op6 == cie_pkg::OP6_DEC || op6 == cie_pkg::OP6_INC || op6 == cie_pkg::OP6_COM
				|| op6 == cie_pkg::OP6_MOV || op6 == cie_pkg::OP6_DECSZ || op6 == cie_pkg::OP6_INCSZ)
			begin
				case (op6)
					cie_pkg::OP6_DEC, cie_pkg::OP6_DECSZ: alu = i_reg_rdata - 8'h01;
					cie_pkg::OP6_INC, cie_pkg::OP6_INCSZ: alu = i_reg_rdata + 8'h01;
					cie_pkg::OP6_COM: alu = ~i_reg_rdata;
					default: alu = i_reg_rdata;
				endcase
				if (dest_reg)
				begin
					o_reg_wr.we = 1'b1;
					o_reg_wr.data = alu;
				end
				else
					state_next.acc = alu;
				if (op6 == cie_pkg::OP6_DECSZ || op6 == cie_pkg::OP6_INCSZ)
					skip = (alu == 8'h00);
				else
					state_next.zero = (alu == 8'h00);
			end
			if (skip || redirect)
				state_next.phase = cie_pkg::ST_FLUSH;
			// A taken skip steps over the discarded word in one go
			if (skip)
				state_next.pc = state_reg.pc + 13'h0002;
		end
		if (i_reset)
		begin
			// No side effects leave the core while it is held in reset
			o_reg_wr.we = 1'b0;
			o_stack_push = 1'b0;
			o_stack_pop = 1'b0;
			o_watchdog_clear = 1'b0;
			state_next = '0;
			state_next.acc = cie_pkg::ACC_RESET;
			state_next.pc = cie_pkg::PC_RESET;
			state_next.expiry_n = 1'b1;
			state_next.sleep_n = 1'b1;
		end
	end

	always_ff @(posedge i_clk)
	begin
		state_reg <= state_next;
	end

	assign o_stack_push_data = state_reg.pc + 13'h0001;
	assign o_pc = state_reg.pc;
	assign o_acc = state_reg.acc;
	assign o_zero = state_reg.zero;
	assign o_expiry_flag_n = state_reg.expiry_n;
	assign o_sleep_flag_n = state_reg.sleep_n;
	assign o_global_irq_enable = state_reg.irq_en;
	assign o_flush = (state_reg.phase == cie_pkg::ST_FLUSH);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence btss_hit_s;
		exec && i_insn[13:10] == cie_pkg::OP4_BTSS && i_reg_rdata[i_insn[9:7]];
	endsequence
	sequence flush_then_exec_s;
		o_flush ##1 !o_flush;
	endsequence
	bit_skip_a: assert property (@(posedge i_clk) disable iff (i_reset)
		btss_hit_s |=> flush_then_exec_s) else $error("bit test did not skip");
	skip_length_a: assert property (@(posedge i_clk) disable iff (i_reset)
		o_flush |=> !o_flush && o_pc == $past(o_pc)) else $error("flush slot pc wrong");
	skip_target_a: assert property (@(posedge i_clk) disable iff (i_reset)
		exec && op6 == cie_pkg::OP6_DECSZ && i_reg_rdata == 8'h01 |=> o_flush && o_pc == $past(o_pc) + 13'h0002)
		else $error("decrement-skip target wrong");
	clear_reg_a: assert property (@(posedge i_clk) disable iff (i_reset)
		exec && op6 == cie_pkg::OP6_CLR && dest_reg |-> o_reg_wr.we && o_reg_wr.data == 8'h00 ##1 o_zero)
		else $error("clear register wrong");
	call_target_a: assert property (@(posedge i_clk) disable iff (i_reset)
		exec && i_insn[13:11] == cie_pkg::OP3_CALL |-> o_stack_push && o_stack_push_data == o_pc + 13'h0001
		##1 o_pc == {$past(i_pc_upper_latch[4:3]), $past(i_insn[10:0])}) else $error("call wrong");
	goto_nopush_a: assert property (@(posedge i_clk) disable iff (i_reset)
		exec && i_insn[13:11] == cie_pkg::OP3_GOTO |-> !o_stack_push && !o_stack_pop ##1 o_flush)
		else $error("branch touched stack");
	clear_acc_a: assert property (@(posedge i_clk) disable iff (i_reset)
		exec && i_insn == cie_pkg::OP_CLRACC |=> o_acc == 8'h00 && o_zero) else $error("clear acc wrong");
	wdt_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
		exec && i_insn == cie_pkg::OP_WDTCLR |-> o_watchdog_clear ##1 o_expiry_flag_n && o_sleep_flag_n)
		else $error("watchdog clear wrong");
	dest_acc_a: assert property (@(posedge i_clk) disable iff (i_reset)
		exec && op6 == cie_pkg::OP6_MOV && !dest_reg |=> o_acc == $past(i_reg_rdata)) else $error("move to acc wrong");
	inc_zero_a: assert property (@(posedge i_clk) disable iff (i_reset)
		exec && op6 == cie_pkg::OP6_INC && i_reg_rdata == 8'hFF |=> o_zero) else $error("increment zero flag");
	decsz_flag_a: assert property (@(posedge i_clk) disable iff (i_reset)
		exec && op6 == cie_pkg::OP6_DECSZ |=> $stable(o_zero)) else $error("decrement-skip moved flag");
	incsz_skip_a: assert property (@(posedge i_clk) disable iff (i_reset)
		exec && op6 == cie_pkg::OP6_INCSZ && i_reg_rdata == 8'hFF |=> o_flush && $stable(o_zero))
		else $error("increment-skip wrong");
	or_lit_a: assert property (@(posedge i_clk) disable iff (i_reset)
		exec && op6 == cie_pkg::OP6_ORLIT |=> o_acc == ($past(o_acc) | $past(i_insn[7:0])))
		else $error("or literal wrong");
	iret_a: assert property (@(posedge i_clk) disable iff (i_reset)
		exec && i_insn == cie_pkg::OP_IRET |-> o_stack_pop ##1 o_global_irq_enable && o_pc == $past(i_stack_head))
		else $error("interrupt return wrong");
	nop_a: assert property (@(posedge i_clk) disable iff (i_reset)
		exec && i_insn == 14'h0000 |=> o_pc == $past(o_pc) + 13'h0001 && $stable(o_acc) && $stable(o_zero))
		else $error("no-operation changed state");
endmodule

// ### hw/cie_pkg.sv
// Package for the core instruction executor: encodings, widths, reset values
package cie_pkg;
	// ----------------------------------------
	// Widths and fields
	// ----------------------------------------
	localparam int INSN_W = 14;
	localparam int PC_W = 13;
	localparam int ADDR_W = 7;
	localparam int BITSEL_LSB = 7;
	localparam int DEST_BIT = 7;
	localparam int LATCH_HI = 4;
	localparam int LATCH_LO = 3;
	localparam int IRQ_EN_BIT = 7;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [12:0] PC_RESET = 13'h0000;
	// ----------------------------------------
	// Exact encodings
	// ----------------------------------------
	localparam logic [13:0] OP_CLRACC = 14'h0103;
	localparam logic [13:0] OP_WDTCLR = 14'h0064;
	localparam logic [13:0] OP_IRET = 14'h0009;
	// ----------------------------------------
	// Byte-op codes: six-bit in bits 13:8, four-bit in bits 13:10, three-bit in bits 13:11
	// ----------------------------------------
	localparam logic [5:0] OP6_MISC = 6'h00;
	localparam logic [5:0] OP6_CLR = 6'h01;
	localparam logic [5:0] OP6_DEC = 6'h03;
	localparam logic [5:0] OP6_MOV = 6'h08;
	localparam logic [5:0] OP6_COM = 6'h09;
	localparam logic [5:0] OP6_INC = 6'h0A;
	localparam logic [5:0] OP6_DECSZ = 6'h0B;
	localparam logic [5:0] OP6_INCSZ = 6'h0F;
	localparam logic [5:0] OP6_ORLIT = 6'h38;
	localparam logic [3:0] OP4_BTSS = 4'h7;
	localparam logic [3:0] OP4_LDLIT = 4'hC;
	localparam logic [2:0] OP3_CALL = 3'h4;
	localparam logic [2:0] OP3_GOTO = 3'h5;

	typedef enum logic [0:0] {ST_EXEC = 1'b0, ST_FLUSH = 1'b1} cie_phase_type;

	typedef struct packed {
		logic we;
		logic [6:0] addr;
		logic [7:0] data;
	} cie_wr_type;

	typedef struct packed {
		cie_phase_type phase;
		logic [12:0] pc;
		logic [7:0] acc;
		logic zero;
		logic expiry_n;
		logic sleep_n;
		logic irq_en;
	} cie_state_type;
endpackage
